// ### hdl/upif_pkg.sv
package upif_pkg;
    // Bus geometry
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    // Register byte addresses
    localparam logic [7:0] OFF_PWR   = 8'h00;
    localparam logic [7:0] OFF_IFLAG = 8'h10;
    localparam logic [7:0] OFF_IEN   = 8'h20;
    localparam logic [7:0] OFF_EEN   = 8'h30;
    localparam logic [7:0] OFF_MODE  = 8'h40;

    // Power control field positions
    localparam int unsigned PC_PWR    = 0;
    localparam int unsigned PC_SUSP   = 1;
    localparam int unsigned PC_BUSY   = 3;
    localparam int unsigned PC_GUARD  = 4;
    localparam int unsigned PC_ACTPND = 7;

    // Interrupt flag positions
    localparam int unsigned IF_STALL  = 7;
    localparam int unsigned IF_ATTACH = 6;
    localparam int unsigned IF_RESUME = 5;
    localparam int unsigned IF_IDLE   = 4;
    localparam int unsigned IF_TOKEN  = 3;
    localparam int unsigned IF_SOF    = 2;
    localparam int unsigned IF_ERR    = 1;
    localparam int unsigned IF_RST    = 0;

    // Mode register field positions
    localparam int unsigned MD_DISCH = 0;
    localparam int unsigned MD_HOST  = 1;

    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Timing, in its own unit, and derived cycle counts
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned K_HOLD_NS     = 2500;
    localparam int unsigned QUIET_NS      = 2500;
    localparam int unsigned IDLE_MS       = 3;
    localparam int unsigned RESUME_CYC =
        (K_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned QUIET_CYC =
        (QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned IDLE_CYC =
        (IDLE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DRAIN_CYC = 8;

    // Counter widths
    localparam int unsigned SHORT_W = 5;
    localparam int unsigned IDLE_W  = 15;
    localparam int unsigned DRAIN_W = 4;

    // Power sequencing, Gray along off -> on -> drain; drain -> off flips both bits
    typedef enum logic [1:0] {
        PWR_OFF   = 2'h0,
        PWR_ON    = 2'h1,
        PWR_DRAIN = 2'h3
    } upif_pwr_t;
endpackage

// ### hdl/upif_top.sv
// Functional notes
// - Discharge bit enables VBUS pull-down path
// - Activity pending until resulting interrupt raised
// - Sleep guard blocks sleep on activity
// - Busy while active or still shutting down
// - Suspend gates USB clock, transceiver low-power
// - Power enable turns module on/off
// - Disabled: outputs inactive, pins released, analog off
// - Flags hardware-set, write-one clears them (here not bit 1, the error summary, which tracks enabled errors)
// - Stall flag on STALL handshake
// - Attach flag: host, quiet 2.5 us, not SE0
// - Resume flag after K-state 2.5 us
// - Idle flag after 3 ms idle bus
// - Token-done flag when token processing completes
// - Clearing token-done advances status FIFO
// - Frame-start flag on SOF or threshold (here ev_sof only, no threshold)
// - Error summary set only by enabled errors
// - Bit 0 is bus reset in device mode
// - Bit 0 is detach in host mode
// - Unimplemented bits read as zero
// - Each flag gated by its enable bit
//
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none

module upif_top #(
    parameter int unsigned IDLE_CYC = upif_pkg::IDLE_CYC
) (
    // Clock, reset, enable
    input  wire logic                        sys_clk,
    input  wire logic                        sys_rst,
    input  wire logic                        clk_en,
    // AXI4-Lite write channels
    input  wire logic [upif_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    // AXI4-Lite read channels
    input  wire logic [upif_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [31:0]                      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    // Line state pins, asynchronous
    input  wire logic                        line_kstate,
    input  wire logic                        line_idle,
    input  wire logic                        line_se0,
    // Protocol engine event pulses, same clock
    input  wire logic                        ev_stall,
    input  wire logic                        ev_attach,
    input  wire logic                        ev_token_done,
    input  wire logic                        ev_sof,
    input  wire logic                        ev_bus_reset,
    input  wire logic                        ev_detach,
    input  wire logic [7:0]                  err_status,
    // Power and pin control
    output logic                             vbus_discharge,
    output logic                             usb_clk_gate_en,
    output logic                             xcvr_low_power,
    output logic                             usb_out_en,
    output logic                             pins_to_usb,
    output logic                             analog_en,
    output logic                             sleep_block,
    output logic                             stat_fifo_adv,
    output logic                             usb_irq
);

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic                           awrdy;
        logic                           wrdy;
        logic                           aw_got;
        logic                           w_got;
        logic [upif_pkg::ADDR_W-1:0]    awaddr;
        logic [7:0]                     wbyte;
        logic                           wlane;
        logic                           bvalid;
        logic [1:0]                     bresp;
        logic                           arrdy;
        logic                           rvalid;
        logic [1:0]                     rresp;
        logic [7:0]                     rbyte;
        logic [7:0]                     pwr;
        logic [7:0]                     flags;
        logic [7:0]                     ien;
        logic [7:0]                     een;
        logic [7:0]                     mode;
        upif_pkg::upif_pwr_t            pst;
        logic [upif_pkg::DRAIN_W-1:0]   drain;
        logic [2:0]                     k_sy;
        logic [2:0]                     i_sy;
        logic [2:0]                     s_sy;
        logic                           k_f;
        logic                           idle_f;
        logic                           se0_f;
        logic [upif_pkg::SHORT_W-1:0]   k_cnt;
        logic [upif_pkg::SHORT_W-1:0]   quiet;
        logic [upif_pkg::IDLE_W-1:0]    idle_cnt;
        logic                           act_pnd;
        logic                           disch;
        logic                           clk_gate;
        logic                           lowpwr;
        logic                           out_en;
        logic                           sleep_blk;
        logic                           fifo_adv;
        logic                           irq;
    } upif_st_t;

    ////////////////////////////////////////////////////////////////////////
    // Byte lane 0 merge, shared by the PWR, IEN, EEN and MODE registers
    function automatic logic [7:0] merge_lane(input logic [7:0] old_v,
                                              input logic [7:0] new_v,
                                              input logic [7:0] wmask,
                                              input logic       lane);
        merge_lane = lane ? ((old_v & ~wmask) | (new_v & wmask)) : old_v;
    endfunction

    // Filtered level follows only once the last two stages agree
    function automatic logic filt(input logic [2:0] sy, input logic cur);
        filt = (sy[1] == sy[2]) ? sy[2] : cur;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    upif_st_t st_r;
    upif_st_t st_nxt;
    logic     do_wr;
    logic     do_rd;
    logic [7:0] setv;
    logic [7:0] clrv;
    logic       pwr_on;
    logic       host;

    // Next-state logic for the whole block
    always_comb begin
        st_nxt = st_r;
        pwr_on = (st_r.pst == upif_pkg::PWR_ON);
        host   = st_r.mode[upif_pkg::MD_HOST];

        // Pin synchronisers, first stage feeds only the second
        st_nxt.k_sy   = {st_r.k_sy[1:0], line_kstate};
        st_nxt.i_sy   = {st_r.i_sy[1:0], line_idle};
        st_nxt.s_sy   = {st_r.s_sy[1:0], line_se0};
        st_nxt.k_f    = filt(st_r.k_sy, st_r.k_f);
        st_nxt.idle_f = filt(st_r.i_sy, st_r.idle_f);
        st_nxt.se0_f  = filt(st_r.s_sy, st_r.se0_f);

        // Line timers saturate so each condition fires once per episode
        st_nxt.k_cnt = (st_r.k_f && st_r.k_cnt != upif_pkg::SHORT_W'(upif_pkg::RESUME_CYC))
                     ? st_r.k_cnt + 1'b1 : (st_r.k_f ? st_r.k_cnt : '0);
        st_nxt.quiet = (st_r.idle_f && st_r.quiet != upif_pkg::SHORT_W'(upif_pkg::QUIET_CYC))
                     ? st_r.quiet + 1'b1 : (st_r.idle_f ? st_r.quiet : '0);
        st_nxt.idle_cnt = (st_r.idle_f && st_r.idle_cnt != upif_pkg::IDLE_W'(IDLE_CYC))
                        ? st_r.idle_cnt + 1'b1 : (st_r.idle_f ? st_r.idle_cnt : '0);

        // Hardware set events, only while the module runs
        setv = '0;
        setv[upif_pkg::IF_STALL]  = ev_stall;
        setv[upif_pkg::IF_ATTACH] = ev_attach && host && !st_r.se0_f
            && st_r.quiet == upif_pkg::SHORT_W'(upif_pkg::QUIET_CYC);
        setv[upif_pkg::IF_RESUME] = st_r.k_f
            && st_r.k_cnt == upif_pkg::SHORT_W'(upif_pkg::RESUME_CYC - 1);
        setv[upif_pkg::IF_IDLE]   = st_r.idle_f
            && st_r.idle_cnt == upif_pkg::IDLE_W'(IDLE_CYC - 1);
        setv[upif_pkg::IF_TOKEN]  = ev_token_done;
        setv[upif_pkg::IF_SOF]    = ev_sof;
        setv[upif_pkg::IF_RST]    = host ? ev_detach : ev_bus_reset;
        setv = pwr_on ? setv : 8'h00;

        // AXI write: address and data taken in either order
        do_wr = st_r.aw_got && st_r.w_got && !st_r.bvalid;
        if (s_axi_awvalid && st_r.awrdy) begin
            st_nxt.aw_got = 1'b1;
            st_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_r.wrdy) begin
            st_nxt.w_got = 1'b1;
            st_nxt.wbyte = s_axi_wdata[7:0];
            st_nxt.wlane = s_axi_wstrb[0];
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end

        // Register writes; unknown offsets answer SLVERR
        clrv = '0;
        if (do_wr) begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got  = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp  = upif_pkg::RESP_OKAY;
            case (st_r.awaddr)
                upif_pkg::OFF_PWR:
                    st_nxt.pwr = merge_lane(st_r.pwr, st_r.wbyte, 8'h13, st_r.wlane);
                upif_pkg::OFF_IFLAG:
                    clrv = st_r.wlane ? (st_r.wbyte & 8'hFD) : 8'h00;
                upif_pkg::OFF_IEN:
                    st_nxt.ien = merge_lane(st_r.ien, st_r.wbyte, 8'hFF, st_r.wlane);
                upif_pkg::OFF_EEN:
                    st_nxt.een = merge_lane(st_r.een, st_r.wbyte, 8'hFF, st_r.wlane);
                upif_pkg::OFF_MODE:
                    st_nxt.mode = merge_lane(st_r.mode, st_r.wbyte, 8'h03, st_r.wlane);
                default:
                    st_nxt.bresp = upif_pkg::RESP_SLVERR;
            endcase
        end

        // Set wins over a clear landing in the same cycle
        st_nxt.flags = (st_r.flags & ~clrv) | setv;
        st_nxt.flags[upif_pkg::IF_ERR] = pwr_on && |(err_status & st_r.een);
        st_nxt.fifo_adv = clrv[upif_pkg::IF_TOKEN];

        // Activity pending until a hardware set event lands on any flag other than the error summary
        st_nxt.act_pnd = (pwr_on && st_r.idle_f && !st_nxt.idle_f)
                       || (st_r.act_pnd && setv == 8'h00);

        // Power sequencing: drain period keeps busy after switch-off
        case (st_r.pst)
            upif_pkg::PWR_OFF: begin
                if (st_r.pwr[upif_pkg::PC_PWR]) begin
                    st_nxt.pst = upif_pkg::PWR_ON;
                end
            end
            upif_pkg::PWR_ON: begin
                if (!st_r.pwr[upif_pkg::PC_PWR]) begin
                    st_nxt.pst   = upif_pkg::PWR_DRAIN;
                    st_nxt.drain = upif_pkg::DRAIN_W'(upif_pkg::DRAIN_CYC - 1);
                end
            end
            upif_pkg::PWR_DRAIN: begin
                if (st_r.drain == '0) begin
                    st_nxt.pst = upif_pkg::PWR_OFF;
                end else begin
                    st_nxt.drain = st_r.drain - 1'b1;
                end
            end
            default: st_nxt.pst = upif_pkg::PWR_OFF;
        endcase
        st_nxt.pwr[upif_pkg::PC_BUSY]   = (st_nxt.pst != upif_pkg::PWR_OFF);
        st_nxt.pwr[upif_pkg::PC_ACTPND] = st_nxt.act_pnd;

        // Pin side controls
        st_nxt.disch    = st_nxt.mode[upif_pkg::MD_DISCH];
        st_nxt.out_en   = (st_nxt.pst == upif_pkg::PWR_ON);
        st_nxt.clk_gate = st_nxt.out_en && !st_nxt.pwr[upif_pkg::PC_SUSP];
        st_nxt.lowpwr   = !st_nxt.out_en || st_nxt.pwr[upif_pkg::PC_SUSP];
        st_nxt.irq      = |(st_nxt.flags & st_nxt.ien);
        st_nxt.sleep_blk = st_nxt.pwr[upif_pkg::PC_GUARD]
            && (!st_nxt.idle_f || st_nxt.act_pnd || st_nxt.irq);

        // AXI read, upper bits always zero
        do_rd = s_axi_arvalid && st_r.arrdy;
        if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end
        if (do_rd) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp  = upif_pkg::RESP_OKAY;
            case (s_axi_araddr)
                upif_pkg::OFF_PWR:   st_nxt.rbyte = st_r.pwr & 8'h9B;
                upif_pkg::OFF_IFLAG: st_nxt.rbyte = st_r.flags;
                upif_pkg::OFF_IEN:   st_nxt.rbyte = st_r.ien;
                upif_pkg::OFF_EEN:   st_nxt.rbyte = st_r.een;
                upif_pkg::OFF_MODE:  st_nxt.rbyte = st_r.mode;
                default: begin
                    st_nxt.rbyte = 8'h00;
                    st_nxt.rresp = upif_pkg::RESP_SLVERR;
                end
            endcase
        end

        // Ready only while the channel's slot is free
        st_nxt.awrdy = !st_nxt.aw_got && !st_nxt.bvalid;
        st_nxt.wrdy  = !st_nxt.w_got && !st_nxt.bvalid;
        st_nxt.arrdy = !st_nxt.rvalid;
    end

    // State register; clock enable freezes everything
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= '0;
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from the state register
    assign s_axi_awready   = st_r.awrdy;
    assign s_axi_wready    = st_r.wrdy;
    assign s_axi_bvalid    = st_r.bvalid;
    assign s_axi_bresp     = st_r.bresp;
    assign s_axi_arready   = st_r.arrdy;
    assign s_axi_rvalid    = st_r.rvalid;
    assign s_axi_rresp     = st_r.rresp;
    assign s_axi_rdata     = {24'h000000, st_r.rbyte};
    assign vbus_discharge  = st_r.disch;
    assign usb_clk_gate_en = st_r.clk_gate;
    assign xcvr_low_power  = st_r.lowpwr;
    assign usb_out_en      = st_r.out_en;
    assign pins_to_usb     = st_r.out_en;
    assign analog_en       = st_r.out_en;
    assign sleep_block     = st_r.sleep_blk;
    assign stat_fifo_adv   = st_r.fifo_adv;
    assign usb_irq         = st_r.irq;

    ////////////////////////////////////////////////////////////////////////
    // Checks, frozen cycles excluded
    sequence s_disch_write;
        do_wr && st_r.awaddr == upif_pkg::OFF_MODE && st_r.wlane
        && st_r.wbyte[upif_pkg::MD_DISCH];
    endsequence
    sequence s_power_drop;
        st_r.pst == upif_pkg::PWR_ON && !st_r.pwr[upif_pkg::PC_PWR];
    endsequence
    chk_disch_on_write: assert property (@(posedge sys_clk) disable iff (sys_rst || !clk_en)
        s_disch_write |=> vbus_discharge)
        else $error("discharge not driven after write");
    chk_busy_drain: assert property (@(posedge sys_clk) disable iff (sys_rst || !clk_en)
        s_power_drop |=> (st_r.pwr[upif_pkg::PC_BUSY] && !usb_out_en) [*8])
        else $error("busy dropped before drain finished");
    chk_resume_time: assert property (@(posedge sys_clk) disable iff (sys_rst || !clk_en)
        (st_r.k_f && pwr_on && st_r.k_cnt == upif_pkg::SHORT_W'(upif_pkg::RESUME_CYC - 1))
        |=> st_r.flags[upif_pkg::IF_RESUME])
        else $error("resume flag missed");
    chk_set_wins: assert property (@(posedge sys_clk) disable iff (sys_rst || !clk_en)
        (setv[upif_pkg::IF_STALL] && clrv[upif_pkg::IF_STALL]) |=> st_r.flags[upif_pkg::IF_STALL])
        else $error("event lost to clear");
    chk_w1c_clear: assert property (@(posedge sys_clk) disable iff (sys_rst || !clk_en)
        (clrv[upif_pkg::IF_SOF] && !setv[upif_pkg::IF_SOF]) |=> !st_r.flags[upif_pkg::IF_SOF])
        else $error("flag not cleared by write one");
    chk_err_masked: assert property (@(posedge sys_clk) disable iff (sys_rst || !clk_en)
        (|(err_status & st_r.een)) == 1'b0 |=> !st_r.flags[upif_pkg::IF_ERR])
        else $error("masked error set summary");
    chk_irq_enabled: assert property (@(posedge sys_clk) disable iff (sys_rst || !clk_en)
        (|(st_r.flags & st_r.ien)) |-> usb_irq)
        else $error("enabled flag without interrupt");
    chk_sleep_guard: assert property (@(posedge sys_clk) disable iff (sys_rst || !clk_en)
        !st_r.pwr[upif_pkg::PC_GUARD] |-> !sleep_block)
        else $error("sleep blocked without guard");
    // One advance pulse per token clear, never one without it
    chk_fifo_advance: assert property (@(posedge sys_clk) disable iff (sys_rst || !clk_en)
        1'b1 |=> stat_fifo_adv == $past(clrv[upif_pkg::IF_TOKEN]))
        else $error("status fifo advance mismatch");
    chk_upper_zero: assert property (@(posedge sys_clk) disable iff (sys_rst || !clk_en)
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    chk_off_quiet: assert property (@(posedge sys_clk) disable iff (sys_rst || !clk_en)
        st_r.pst == upif_pkg::PWR_OFF |-> !usb_out_en && !analog_en && !usb_clk_gate_en)
        else $error("outputs active while disabled");
    chk_attach_host: assert property (@(posedge sys_clk) disable iff (sys_rst || !clk_en)
        !host |=> !$rose(st_r.flags[upif_pkg::IF_ATTACH]))
        else $error("attach set outside host mode");

endmodule // upif_top

`default_nettype wire

// ### tb/upif_line_model.sv
`timescale 1ns/1ps
`default_nettype none
module upif_line_model (
    // Clock and resume request
    input  wire logic       sys_clk,
    input  wire logic       k_go,
    input  wire logic [7:0] k_len,
    // Line levels towards the block
    output logic            line_kstate,
    output logic            line_idle,
    output logic            line_se0
);
    logic [7:0] left_r = 8'h00;
    // K held k_len cycles; a short burst must not count as wake-up
    always_ff @(posedge sys_clk) begin
        if (k_go)
            left_r <= k_len;
        else if (left_r != 8'h00)
            left_r <= left_r - 8'h01;
    end
    // Idle J between bursts; no SE0 in these runs
    assign line_kstate = (left_r != 8'h00);
    assign line_idle   = (left_r == 8'h00);
    assign line_se0    = 1'b0;
endmodule // upif_line_model
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        sys_clk = 1'b0, sys_rst = 1'b1, k_go = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, err = 8'h00, k_len = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, line_kstate, line_idle, line_se0;
    logic        vbus_discharge, usb_clk_gate_en, xcvr_low_power, usb_out_en, pins_to_usb;
    logic        analog_en, sleep_block, stat_fifo_adv, usb_irq;
    logic [5:0]  ev = 6'h00;
    int          miscompares = 0, n_tests = 0, i, n_adv = 0;
    int          fb[4] = '{7, 3, 2, 0};
    int          ei[4] = '{0, 2, 3, 4};
    // Idle threshold cut to 40 cycles to keep the run short
    upif_top #(.IDLE_CYC(40)) i_dut (
        .sys_clk, .sys_rst, .clk_en(1'b1), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .line_kstate, .line_idle,
        .line_se0, .ev_stall(ev[0]), .ev_attach(ev[1]), .ev_token_done(ev[2]), .ev_sof(ev[3]),
        .ev_bus_reset(ev[4]), .ev_detach(ev[5]), .err_status(err), .vbus_discharge,
        .usb_clk_gate_en, .xcvr_low_power, .usb_out_en, .pins_to_usb, .analog_en,
        .sleep_block, .stat_fifo_adv, .usb_irq);
    upif_line_model i_line (.sys_clk, .k_go, .k_len, .line_kstate, .line_idle, .line_se0);
    always #50 sys_clk = ~sys_clk;
    // Count status fifo advance pulses, one per token-done clear
    always @(posedge sys_clk) if (stat_fifo_adv === 1'b1) n_adv <= n_adv + 1;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict;
        $display("Checks %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // One bus access; each valid drops once taken, one spare edge so no double drive
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        s_axi_awaddr  <= a;
        s_axi_araddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= w;
        s_axi_wvalid  <= w;
        s_axi_bready  <= w;
        s_axi_arvalid <= !w;
        s_axi_rready  <= !w;
        for (n = 0; n < 50; n++) begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_bvalid || s_axi_rvalid) break;
        end
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        v = s_axi_rdata;
        r = w ? s_axi_bresp : s_axi_rresp;
        if (n == 50) miscompares++;
        if (n == 50) give_verdict();
        @(posedge sys_clk);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        chk(v & m, e);
    endtask
    task automatic kburst(input logic [7:0] len, input int gap);
        k_len <= len;
        k_go  <= 1'b1;
        @(posedge sys_clk);
        k_go  <= 1'b0;
        wt(gap);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        wt(12);
        sys_rst <= 1'b0;
        wt(2);
        rdc(upif_pkg::OFF_PWR, 32'hFFFFFFFF, 32'h0);
        rdc(upif_pkg::OFF_IFLAG, 32'hFFFFFFFF, 32'h0);
        rdc(8'h50, 32'hFFFFFFFF, 32'h0);
        chk({30'h0, r}, {30'h0, upif_pkg::RESP_SLVERR});
        acc(1'b1, upif_pkg::OFF_PWR, 32'h11);
        rdc(upif_pkg::OFF_PWR, 32'h7F, 32'h19);
        chk({28'h0, usb_out_en, pins_to_usb, analog_en, usb_clk_gate_en}, 32'hF);
        wt(60);
        rdc(upif_pkg::OFF_IFLAG, 32'h10, 32'h10);
        acc(1'b1, upif_pkg::OFF_IEN, 32'hCF);
        acc(1'b1, upif_pkg::OFF_EEN, 32'h01);
        // Each event: set, survives a zero write, raises irq, cleared by one
        for (i = 0; i < 4; i++) begin
            ev[ei[i]] <= 1'b1;
            @(posedge sys_clk);
            ev[ei[i]] <= 1'b0;
            acc(1'b1, upif_pkg::OFF_IFLAG, 32'h0);
            rdc(upif_pkg::OFF_IFLAG, 32'hEF, 32'h1 << fb[i]);
            chk({31'h0, usb_irq}, 32'h1);
            acc(1'b1, upif_pkg::OFF_IFLAG, 32'h1 << fb[i]);
            rdc(upif_pkg::OFF_IFLAG, 32'hEF, 32'h0);
            chk({31'h0, usb_irq}, 32'h0);
        end
        chk(n_adv, 32'h1);
        // Stall lands in the very cycle its clear is written
        fork
            acc(1'b1, upif_pkg::OFF_IFLAG, 32'h80);
            begin
                @(posedge sys_clk);
                ev[0] <= 1'b1;
                @(posedge sys_clk);
                ev[0] <= 1'b0;
            end
        join
        rdc(upif_pkg::OFF_IFLAG, 32'h80, 32'h80);
        chk({31'h0, sleep_block}, 32'h1);
        err <= 8'h02;
        wt(3);
        rdc(upif_pkg::OFF_IFLAG, 32'h2, 32'h0);
        err <= 8'h01;
        wt(3);
        rdc(upif_pkg::OFF_IFLAG, 32'h2, 32'h2);
        err <= 8'h00;
        kburst(8'h0A, 20);
        rdc(upif_pkg::OFF_IFLAG, 32'h20, 32'h0);
        rdc(upif_pkg::OFF_PWR, 32'h80, 32'h80);
        kburst(8'h28, 50);
        rdc(upif_pkg::OFF_IFLAG, 32'h20, 32'h20);
        rdc(upif_pkg::OFF_PWR, 32'h80, 32'h00);
        acc(1'b1, upif_pkg::OFF_PWR, 32'h13);
        wt(2);
        chk({30'h0, usb_clk_gate_en, xcvr_low_power}, 32'h1);
        acc(1'b1, upif_pkg::OFF_MODE, 32'h1);
        wt(2);
        chk({31'h0, vbus_discharge}, 32'h1);
        acc(1'b1, upif_pkg::OFF_MODE, 32'h0);
        wt(2);
        chk({31'h0, vbus_discharge}, 32'h0);
        // Attach and detach count only in host mode
        for (i = 0; i < 2; i++) begin
            acc(1'b1, upif_pkg::OFF_MODE, 32'h2 * i);
            ev <= 6'h22;
            @(posedge sys_clk);
            ev <= 6'h00;
            rdc(upif_pkg::OFF_IFLAG, 32'h40, 32'h40 * i);
            rdc(upif_pkg::OFF_IFLAG, 32'h01, 32'h01 * i);
        end
        acc(1'b1, upif_pkg::OFF_MODE, 32'h0);
        // Power off: busy lingers, no writes until it clears
        acc(1'b1, upif_pkg::OFF_PWR, 32'h0);
        rdc(upif_pkg::OFF_PWR, 32'h7F, 32'h08);
        for (i = 0; i < 20 && v[3] !== 1'b0; i++) rdc(upif_pkg::OFF_PWR, 32'h0, 32'h0);
        rdc(upif_pkg::OFF_PWR, 32'h7F, 32'h0);
        chk({29'h0, usb_out_en, pins_to_usb, analog_en}, 32'h0);
        give_verdict();
    end
endmodule // tb
`default_nettype wire
